// File: ecr_clock_reset.sv
// Clock routing and reset sequencing for the Ethernet MAC and coding core.
// Assumes ref_clk is the housekeeping clock and that the surrounding logic
// supplies the five asynchronous resets and the reference-stable level.
`timescale 1ns/1ns
`default_nettype none
`include "ecr_map.svh"

////////////////////////////////////////////////////////////////////////////
// How it works
// - Five asynchronous reset inputs, each resetting its own part; the MAC transmit one also resets transmit coding.
// - Writable dynamic reset bits reset individual parts during operation; the MAC transmit bit also resets transmit coding.
// - Housekeeping and control logic run from the housekeeping clock input.
// - Synchronous Ethernet builds feed the transmit PLL from a dedicated reference.
// - Synchronous Ethernet builds feed the receive CDR from a dedicated reference.
// - Synchronous Ethernet builds export the recovered CDR clock at top level.
// - Coding clock is 257.8125, 201.416 or 156.25 MHz by build.
module ecr_clock_reset
  import ecr_pkg::*;
#(
  parameter ecr_variant_t VARIANT = ECR_STANDARD,
  parameter bit SYNC_E = 1'b0
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clock_enable,
  input wire logic mac_receive_async_reset,
  input wire logic mac_transmit_async_reset,
  input wire logic coding_receive_async_reset,
  input wire logic coding_transmit_async_reset,
  input wire logic medium_attachment_async_reset,
  input wire logic [`ECR_PART_COUNT-1:0] dynamic_reset,
  input wire logic ref_clock_stable,
  input wire logic shared_ref_clk,
  input wire logic tx_ref_clk,
  input wire logic rx_ref_clk,
  input wire logic cdr_recovered_clk,
  output logic tx_pll_ref_clk,
  output logic rx_cdr_ref_clk,
  output logic recovered_clk_out,
  output logic mac_receive_reset,
  output logic mac_transmit_reset,
  output logic coding_receive_reset,
  output logic coding_transmit_reset,
  output logic medium_attachment_reset,
  output logic waiting_for_ref,
  output logic [31:0] pcs_clk_hz
);
  typedef struct packed {
    ecr_phase_t phase;
    logic [31:0] pcs_hz;
  } ecr_main_state_t;

  ecr_main_state_t st;
  ecr_main_state_t next_st;
  logic [`ECR_PART_COUNT-1:0] part_arst;
  logic [`ECR_PART_COUNT-1:0] part_hold;
  logic [`ECR_PART_COUNT-1:0] part_rst;

  ////////////////////////////////////////////////////////////////////////////
  // Reference routing. The build option is static, so these muxes never switch
  // while running; a live clock mux here would be a glitch hazard.
  assign tx_pll_ref_clk = SYNC_E ? tx_ref_clk : shared_ref_clk;
  assign rx_cdr_ref_clk = SYNC_E ? rx_ref_clk : shared_ref_clk;
  assign recovered_clk_out = SYNC_E ? cdr_recovered_clk : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Per-part asynchronous sources; the global reset reaches every part.
  always_comb
  begin
    part_arst = '0;
    part_arst[`ECR_PART_MAC_RX] = reset | mac_receive_async_reset;
    part_arst[`ECR_PART_MAC_TX] = reset | mac_transmit_async_reset;
    part_arst[`ECR_PART_CODING_RX] = reset | coding_receive_async_reset;
    // The MAC transmit reset also drives transmit coding, so a careless release order
    // outside cannot let the transmit coder run while the transmit MAC is still in reset.
    part_arst[`ECR_PART_CODING_TX] = reset | coding_transmit_async_reset
      | mac_transmit_async_reset;
    part_arst[`ECR_PART_MEDIUM] = reset | medium_attachment_async_reset;
  end

  // Synchronous holds: dynamic bits plus the wait for a stable reference.
  always_comb
  begin
    part_hold = dynamic_reset | {`ECR_PART_COUNT{st.phase != ECR_RUN}};
    part_hold[`ECR_PART_CODING_TX] = part_hold[`ECR_PART_CODING_TX]
      | dynamic_reset[`ECR_PART_MAC_TX];
  end

  ////////////////////////////////////////////////////////////////////////////
  // One synchroniser per part, each joined through its own bundle.
  genvar g;
  generate
    for (g = 0; g < `ECR_PART_COUNT; g++)
    begin : g_part
      ecr_rst_if link ();
      assign link.arst = part_arst[g];
      assign link.hold = part_hold[g];
      assign link.ce = clock_enable;
      assign part_rst[g] = link.rst_out;
      ecr_reset_sync #(.STAGES(`ECR_SYNC_STAGES)) u_sync (
        .ref_clk(ref_clk),
        .port(link.sync)
      );
    end
  endgenerate

  assign mac_receive_reset = part_rst[`ECR_PART_MAC_RX];
  assign mac_transmit_reset = part_rst[`ECR_PART_MAC_TX];
  assign coding_receive_reset = part_rst[`ECR_PART_CODING_RX];
  assign coding_transmit_reset = part_rst[`ECR_PART_CODING_TX];
  assign medium_attachment_reset = part_rst[`ECR_PART_MEDIUM];

  ////////////////////////////////////////////////////////////////////////////
  // Phase tracking. A reference that drops while running sends every part back
  // into hold, since the PLLs behind it are no longer trustworthy.
  always_comb
  begin
    next_st = st;
    if (clock_enable)
    begin
      next_st.pcs_hz = ecr_pcs_clk_hz(VARIANT);
      case (st.phase)
        ECR_WAIT_REF:
        begin
          if (ref_clock_stable)
            next_st.phase = ECR_RUN;
        end
        ECR_RUN:
        begin
          if (!ref_clock_stable)
            next_st.phase = ECR_WAIT_REF;
        end
        default: next_st.phase = ECR_WAIT_REF;
      endcase
    end
  end

  // All housekeeping state sits on the housekeeping clock.
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      st.phase <= ECR_WAIT_REF;
      st.pcs_hz <= `ECR_PCS_HZ_STANDARD;
    end
    else
      st <= next_st;
  end

  assign waiting_for_ref = (st.phase != ECR_RUN);
  assign pcs_clk_hz = st.pcs_hz;

  ////////////////////////////////////////////////////////////////////////////
  a_part_async_in: assert property (@(posedge ref_clk) disable iff (reset)
    mac_receive_async_reset |-> mac_receive_reset
      && (medium_attachment_async_reset ? medium_attachment_reset : 1'b1))
    else $error("Asserted part reset input did not reach its output.");

  a_tx_pair_held: assert property (@(posedge ref_clk) disable iff (reset)
    mac_transmit_reset |-> coding_transmit_reset)
    else $error("Transmit coding left reset while transmit MAC still in reset.");

  a_ref_wait_hold: assert property (@(posedge ref_clk) disable iff (reset)
    (!ref_clock_stable && clock_enable) ##1 clock_enable |=>
      mac_receive_reset && coding_receive_reset && medium_attachment_reset)
    else $error("A part left reset while the reference was unstable.");

  a_dynamic_reset: assert property (@(posedge ref_clk) disable iff (reset)
    (dynamic_reset[`ECR_PART_MEDIUM] && clock_enable) |=> medium_attachment_reset)
    else $error("Dynamic reset bit did not reset its part.");

  a_freeze_phase: assert property (@(posedge ref_clk) disable iff (reset)
    !clock_enable |=> $stable(st.phase))
    else $error("Phase changed while the clock enable was low.");

  a_tx_ref_route: assert property (@(posedge ref_clk) disable iff (reset)
    tx_pll_ref_clk == (SYNC_E ? tx_ref_clk : shared_ref_clk))
    else $error("Transmit PLL reference taken from the wrong input.");

  a_rx_ref_route: assert property (@(posedge ref_clk) disable iff (reset)
    rx_cdr_ref_clk == (SYNC_E ? rx_ref_clk : shared_ref_clk))
    else $error("Receive CDR reference taken from the wrong input.");

  a_recovered_out: assert property (@(posedge ref_clk) disable iff (reset)
    recovered_clk_out == (SYNC_E & cdr_recovered_clk))
    else $error("Recovered clock export wrong for this build.");

  a_pcs_rate: assert property (@(posedge ref_clk) disable iff (reset)
    $past(clock_enable) && !$past(reset) |-> pcs_clk_hz == ecr_pcs_clk_hz(VARIANT))
    else $error("Coding clock rate does not match the build.");

  a_release_sync: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(mac_receive_reset) |-> $past(!mac_receive_async_reset, 1)
      && $past(!mac_receive_async_reset, 2) && $past(!waiting_for_ref, 1))
    else $error("MAC receive reset released without synchronisation.");
endmodule : ecr_clock_reset
`default_nettype wire

// File: ecr_map.svh
// Named constants for the Ethernet core clock and reset sequencer.
// Assumes it is included by bare name before the package and the modules.
`ifndef ECR_MAP_SVH
`define ECR_MAP_SVH
// Number of independently reset parts of the core.
`define ECR_PART_COUNT 5
// Index of each part in the reset vectors.
`define ECR_PART_MAC_RX 0
`define ECR_PART_MAC_TX 1
`define ECR_PART_CODING_RX 2
`define ECR_PART_CODING_TX 3
`define ECR_PART_MEDIUM 4
// Flip-flops in each release synchroniser.
`define ECR_SYNC_STAGES 3
// Coding-layer clock derived from the reference, in hertz, per build.
`define ECR_PCS_HZ_STANDARD 32'h0F5DE814
`define ECR_PCS_HZ_CAUI4 32'h0C015D40
`define ECR_PCS_HZ_LOW_RATE 32'h09502F90
// Recommended MAC clock rates supplied from outside, in hertz.
`define ECR_MAC_HZ_STANDARD 32'h12C684C0
`define ECR_MAC_HZ_LOW_RATE 32'h0B60E720
`endif

// File: ecr_pkg.sv
// Types shared by the clock and reset sequencer modules.
// Assumes ecr_map.svh is available on the include path.
`include "ecr_map.svh"
package ecr_pkg;
  // Build flavour of the core, which sets the coding-layer clock rate.
  typedef enum logic [1:0] {
    ECR_STANDARD = 2'b00,
    ECR_CAUI4 = 2'b01,
    ECR_LOW_RATE = 2'b10
  } ecr_variant_t;
  // Sequencer phase: waiting for a stable reference, or running.
  typedef enum logic [1:0] {
    ECR_WAIT_REF = 2'b00,
    ECR_RUN = 2'b01
  } ecr_phase_t;
  // Rate of the coding-layer clock for a given build.
  function automatic logic [31:0] ecr_pcs_clk_hz(input ecr_variant_t v);
    case (v)
      ECR_STANDARD: ecr_pcs_clk_hz = `ECR_PCS_HZ_STANDARD;
      ECR_CAUI4: ecr_pcs_clk_hz = `ECR_PCS_HZ_CAUI4;
      ECR_LOW_RATE: ecr_pcs_clk_hz = `ECR_PCS_HZ_LOW_RATE;
      default: ecr_pcs_clk_hz = `ECR_PCS_HZ_STANDARD;
    endcase
  endfunction : ecr_pcs_clk_hz
endpackage : ecr_pkg

// File: ecr_reset_sync.sv
// One reset synchroniser: asserts at once, releases after a chain of flops.
// Assumes arst is asynchronous and hold and ce are synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ecr_map.svh"
module ecr_reset_sync
  import ecr_pkg::*;
#(
  parameter int STAGES = `ECR_SYNC_STAGES
)
(
  input wire logic ref_clk,
  ecr_rst_if.sync port
);
  typedef struct packed {
    logic [STAGES-1:0] chain;
  } ecr_sync_state_t;

  ecr_sync_state_t st;
  ecr_sync_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // A synchronous hold refills the chain; otherwise zeros shift toward the output.
  always_comb
  begin
    next_st = st;
    if (port.ce)
    begin
      if (port.hold)
        next_st.chain = '1;
      else
        next_st.chain = {st.chain[STAGES-2:0], 1'b0};
    end
  end

  // Assertion is immediate; only the release is retimed, so glitches never shorten it.
  always_ff @(posedge ref_clk or posedge port.arst)
  begin
    if (port.arst)
      st <= '1;
    else
      st <= next_st;
  end

  // Only the last flop leaves the module, so the first one is never sampled twice.
  assign port.rst_out = st.chain[STAGES-1];

  ////////////////////////////////////////////////////////////////////////////
  a_hold_sets_out: assert property (@(posedge ref_clk) disable iff (port.arst)
    port.hold && port.ce |=> port.rst_out)
    else $error("Synchronous hold did not assert the reset output.");

  a_release_retimed: assert property (@(posedge ref_clk)
    $fell(port.rst_out) |-> $past(!port.hold, 1) && $past(!port.hold, 2))
    else $error("Reset output released without a full synchroniser pass.");
endmodule : ecr_reset_sync
`default_nettype wire

// File: ecr_rst_if.sv
// Bundle between the sequencer and one reset synchroniser.
// Assumes all signals belong to the housekeeping clock domain except arst.
`timescale 1ns/1ns
`default_nettype none
interface ecr_rst_if;
  logic arst;
  logic hold;
  logic ce;
  logic rst_out;
  modport sync (input arst, input hold, input ce, output rst_out);
  modport ctrl (output arst, output hold, output ce, input rst_out);
endinterface : ecr_rst_if
`default_nettype wire

// File: ecr_user_logic.sv
// Model of the user logic that drives the core's five asynchronous resets.
// Assumes ref_ok is the reference-stable level, synchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
`include "ecr_map.svh"
module ecr_user_logic
  import ecr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic ref_ok,
  input wire logic [4:0] req,
  output logic [4:0] arst
);
  logic [4:0] next_arst;
  // MAC clocks this logic would supply; they never reach the sequencer itself.
  localparam logic [31:0] MAC_CLK_HZ = `ECR_MAC_HZ_STANDARD;
  // Hold every part until the reference is stable, so all parts leave together.
  always_comb
  begin
    next_arst = req | {5{~ref_ok}};
    next_arst[3] = next_arst[3] | next_arst[1];
  end
  // Registered, so each assertion lasts at least one housekeeping cycle.
  always_ff @(posedge ref_clk)
  begin
    arst <= next_arst;
  end
endmodule : ecr_user_logic
`default_nettype wire

// File: tb_top.sv
// Self-checking bench for the clock and reset sequencer, three builds side by side.
// Assumes the design files and ecr_user_logic are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import ecr_pkg::*;
;
  logic ref_clk, reset, clock_enable, ref_ok;
  logic [4:0] req, dyn;
  logic [3:0] clks;
  wire [4:0] arst;
  wire [2:0] tpl, rcr, rco, wait_ref;
  wire [4:0] prt [3];
  wire [31:0] hz [3];
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  ecr_user_logic partner (.ref_clk(ref_clk), .ref_ok(ref_ok), .req(req), .arst(arst));
  // Build 0 standard, build 1 four-lane with separate references, build 2 low rate.
  for (genvar g = 0; g < 3; g++)
  begin : bld
    ecr_clock_reset #(.VARIANT(ecr_variant_t'(g)), .SYNC_E(g == 1)) uut (
      .ref_clk(ref_clk), .reset(reset), .clock_enable(clock_enable),
      .mac_receive_async_reset(arst[0]), .mac_transmit_async_reset(arst[1]),
      .coding_receive_async_reset(arst[2]), .coding_transmit_async_reset(arst[3]),
      .medium_attachment_async_reset(arst[4]), .dynamic_reset(dyn),
      .ref_clock_stable(ref_ok), .shared_ref_clk(clks[0]), .tx_ref_clk(clks[1]),
      .rx_ref_clk(clks[2]), .cdr_recovered_clk(clks[3]), .tx_pll_ref_clk(tpl[g]),
      .rx_cdr_ref_clk(rcr[g]), .recovered_clk_out(rco[g]), .mac_receive_reset(prt[g][0]),
      .mac_transmit_reset(prt[g][1]), .coding_receive_reset(prt[g][2]),
      .coding_transmit_reset(prt[g][3]), .medium_attachment_reset(prt[g][4]),
      .waiting_for_ref(wait_ref[g]), .pcs_clk_hz(hz[g]));
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running housekeeping clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Cuts a hang short; the whole run needs only about 120 cycles.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // Lets n edges pass, then waits for their updates to land.
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk("wait in reset", wait_ref[0], 1'b1);
    chk("parts in reset", prt[0], 5'h1F);
    @(posedge ref_clk);
    reset <= 1'b0;
    step(1);
    chk("wait released", wait_ref[0], 1'b0);
    chk("wait released b1", wait_ref[1], 1'b0);
    chk("wait released b2", wait_ref[2], 1'b0);
    step(2);
    chk("parts held", prt[0], 5'h1F);
    step(1);
    chk("parts released", prt[0], 5'h00);
    chk("parts released b1", prt[1], 5'h00);
    chk("parts released b2", prt[2], 5'h00);
    chk("rate standard", hz[0], 32'h0F5DE814);
    chk("rate four lane", hz[1], 32'h0C015D40);
    chk("rate low", hz[2], 32'h09502F90);
    $display("Test reset release done");
  endtask : t_reset
  // Each input alone; a transmit MAC reset must take the transmit coding part along.
  task automatic t_async();
    logic [4:0] exp;
    for (int i = 0; i < 5; i++)
    begin
      exp = (5'h01 << i) | ((i == 1) ? 5'h08 : 5'h00);
      @(posedge ref_clk);
      req <= 5'h01 << i;
      step(2);
      chk("async hold", prt[0], exp);
      @(posedge ref_clk);
      req <= 5'h00;
      step(3);
      chk("async tail", prt[0], exp);
      step(1);
      chk("async release", prt[0], 5'h00);
    end
    $display("Test async resets done");
  endtask : t_async
  task automatic t_dyn();
    logic [4:0] exp;
    for (int i = 0; i < 5; i++)
    begin
      exp = (5'h01 << i) | ((i == 1) ? 5'h08 : 5'h00);
      @(posedge ref_clk);
      dyn <= 5'h01 << i;
      step(1);
      chk("dyn hold", prt[0], exp);
      @(posedge ref_clk);
      dyn <= 5'h00;
      step(2);
      chk("dyn tail", prt[0], exp);
      step(1);
      chk("dyn release", prt[0], 5'h00);
    end
    $display("Test dynamic resets done");
  endtask : t_dyn
  // Reference drop, then recovery while the clock enable stalls the sequencer.
  task automatic t_ref();
    @(posedge ref_clk);
    ref_ok <= 1'b0;
    step(2);
    chk("wait on drop", wait_ref[0], 1'b1);
    chk("parts on drop", prt[0], 5'h1F);
    @(posedge ref_clk);
    clock_enable <= 1'b0;
    ref_ok <= 1'b1;
    step(6);
    chk("frozen wait", wait_ref[0], 1'b1);
    chk("frozen parts", prt[0], 5'h1F);
    @(posedge ref_clk);
    clock_enable <= 1'b1;
    step(6);
    chk("resumed", prt[0], 5'h00);
    $display("Test reference drop done");
  endtask : t_ref
  task automatic t_route();
    for (int v = 0; v < 16; v++)
    begin
      @(posedge ref_clk);
      clks <= v[3:0];
      #1;
      chk("tx ref std", tpl[0], v[0]);
      chk("cdr ref std", rcr[0], v[0]);
      chk("recovered std", rco[0], 1'b0);
      chk("tx ref sync", tpl[1], v[1]);
      chk("cdr ref sync", rcr[1], v[2]);
      chk("recovered sync", rco[1], v[3]);
      chk("tx ref low", tpl[2], v[0]);
      chk("cdr ref low", rcr[2], v[0]);
      chk("recovered low", rco[2], 1'b0);
    end
    $display("Test clock routing done");
  endtask : t_route
  // Main sequence.
  initial
  begin
    reset <= 1'b1;
    clock_enable <= 1'b1;
    ref_ok <= 1'b1;
    req <= 5'h00;
    dyn <= 5'h00;
    clks <= 4'h0;
    step(10);
    t_reset();
    t_async();
    t_dyn();
    t_ref();
    t_route();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
